/* src/rtc_i2c_pkg.sv */
// Purpose: Shared constants and state types for the RTC serial access link
// Assumes: Host on CLK (25 MHz), target sampling on the link clock
// Notes:   Target register space is 48 bytes, pointer 00h..2Fh
package rtc_i2c_pkg;

  // Addressing
  localparam logic [6:0] TARGET_ADDR = 7'h51;
  localparam logic [7:0] ADDR_BYTE_W = {TARGET_ADDR, 1'b0};
  localparam logic [7:0] ADDR_BYTE_R = {TARGET_ADDR, 1'b1};

  // Register space
  localparam logic [7:0] PTR_MAX     = 8'h2F;
  localparam logic [5:0] PTR_LAST    = 6'h2F;
  localparam logic [5:0] PTR_RESET   = 6'h00;
  localparam int         REG_COUNT   = 48;
  localparam logic [7:0] REG_RESET   = 8'h00;

  // Bit counting
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [3:0] ACK_BIT     = 4'h8;

  // Serial clock timing
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         QTR_NS        = 625;
  localparam int         QTR_CYC       =
    (QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] QTR_LAST      = 5'(QTR_CYC - 1);

  // Write data buffer
  localparam int         FIFO_DEPTH    = 4;
  localparam int         BYTE_W        = 8;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_BYTE  = 3'h2,
    ST_HOLD  = 3'h3,
    ST_STOP  = 3'h4
  } host_state_t;

  typedef enum logic [2:0] {
    STEP_ADDR_W = 3'h0,
    STEP_PTR    = 3'h1,
    STEP_WDATA  = 3'h2,
    STEP_ADDR_R = 3'h3,
    STEP_RDATA  = 3'h4
  } host_step_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_PTR   = 3'h2,
    S_WDATA = 3'h3,
    S_ACK   = 3'h4,
    S_RDATA = 3'h5,
    S_MACK  = 3'h6
  } target_state_t;

endpackage : rtc_i2c_pkg

/* src/rtc_i2c_if.sv */
// Purpose: Two-wire link between host and target, open-drain resolved
// Assumes: A low is driven only while an output enable is high
// Notes:   Released lines read high, as with pull-ups
`timescale 1ns/100ps
interface rtc_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                  input  scl, sda);
  modport target (output sda_s_o, sda_s_oe,
                  input  scl, sda);
endinterface : rtc_i2c_if

/* src/rtc_i2c_target.sv */
// Purpose: Target end of the RTC serial register access link
// Assumes: LINK_CLK well above four times the serial clock rate
// Notes:   Holds the 48-byte register space; LOAD port lets the clock core
//          update contents
`timescale 1ns/100ps
module rtc_i2c_target (
  // Link
  rtc_i2c_if.target           LINK,
  // Clock and reset
  input  wire logic           LINK_CLK,
  input  wire logic           RST_N,
  // Supply state
  input  wire logic           ON_BATTERY,
  // Register load from clock core
  input  wire logic           LOAD_EN,
  input  wire logic [5:0]     LOAD_ADDR,
  input  wire logic [7:0]     LOAD_DATA,
  // Write notification
  output logic                WR_STROBE,
  output logic      [5:0]     WR_ADDR,
  output logic      [7:0]     WR_DATA,
  // Status
  output logic      [5:0]     PTR,
  output logic                BUSY
);

  function automatic logic [5:0] inc_ptr(input logic [5:0] p);
    inc_ptr = (p == rtc_i2c_pkg::PTR_LAST) ? rtc_i2c_pkg::PTR_RESET
                                           : 6'(p + 6'h01);
  endfunction : inc_ptr

  logic                        scl_q1;
  logic                        scl_s;
  logic                        scl_d;
  logic                        sda_q1;
  logic                        sda_s;
  logic                        sda_d;
  logic                        bat_q1;
  logic                        bat_s;
  rtc_i2c_pkg::target_state_t  state;
  rtc_i2c_pkg::target_state_t  ret;
  logic [2:0]                  bit_cnt;
  logic [7:0]                  shreg;
  logic                        byte_done;
  logic                        rw;
  logic                        ignore;
  logic                        mack_ok;
  logic                        sda_drive;
  logic [5:0]                  ptr;
  logic [7:0]                  mem [rtc_i2c_pkg::REG_COUNT];
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_det;
  logic                        stop_det;
  logic                        act;
  logic                        last_bit;
  logic [7:0]                  rx_byte;
  logic                        ptr_load;
  logic                        wr_fire;
  logic                        rd_step;

  // Pins cross into the link domain
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q1 <= 1'b1;
      scl_s  <= 1'b1;
      scl_d  <= 1'b1;
      sda_q1 <= 1'b1;
      sda_s  <= 1'b1;
      sda_d  <= 1'b1;
      bat_q1 <= 1'b0;
      bat_s  <= 1'b0;
    end else begin
      scl_q1 <= LINK.scl;
      scl_s  <= scl_q1;
      scl_d  <= scl_s;
      sda_q1 <= LINK.sda;
      sda_s  <= sda_q1;
      sda_d  <= sda_s;
      bat_q1 <= ON_BATTERY;
      bat_s  <= bat_q1;
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
  assign act       = !bat_s && !start_det && !stop_det;
  assign last_bit  = (bit_cnt == rtc_i2c_pkg::BIT_LAST);
  assign rx_byte   = {shreg[6:0], sda_s};
  assign ptr_load  = act && scl_rise && state == rtc_i2c_pkg::S_PTR
                     && last_bit;
  assign wr_fire   = act && scl_rise && state == rtc_i2c_pkg::S_WDATA
                     && last_bit && !ignore;
  assign rd_step   = act && scl_rise && state == rtc_i2c_pkg::S_RDATA
                     && last_bit;

  // Protocol sequencer
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state     <= rtc_i2c_pkg::S_IDLE;
      ret       <= rtc_i2c_pkg::S_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_done <= 1'b0;
      rw        <= 1'b0;
      ignore    <= 1'b0;
      mack_ok   <= 1'b0;
      sda_drive <= 1'b0;
    end else if (bat_s) begin
      state     <= rtc_i2c_pkg::S_IDLE;
      sda_drive <= 1'b0;
      byte_done <= 1'b0;
    end else if (start_det) begin
      state     <= rtc_i2c_pkg::S_ADDR;
      bit_cnt   <= 3'h0;
      byte_done <= 1'b0;
      ignore    <= 1'b0;
      sda_drive <= 1'b0;
    end else if (stop_det) begin
      state     <= rtc_i2c_pkg::S_IDLE;
      byte_done <= 1'b0;
      sda_drive <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        rtc_i2c_pkg::S_ADDR: begin
          shreg   <= rx_byte;
          bit_cnt <= 3'(bit_cnt + 3'h1);
          if (last_bit) begin
            if (rx_byte[7:1] == rtc_i2c_pkg::TARGET_ADDR) begin
              byte_done <= 1'b1;
              rw        <= rx_byte[0];
            end else begin
              state <= rtc_i2c_pkg::S_IDLE;
            end
          end
        end
        rtc_i2c_pkg::S_PTR, rtc_i2c_pkg::S_WDATA: begin
          shreg   <= rx_byte;
          bit_cnt <= 3'(bit_cnt + 3'h1);
          if (last_bit) begin
            byte_done <= 1'b1;
          end
          if (ptr_load && rx_byte > rtc_i2c_pkg::PTR_MAX) begin
            ignore <= 1'b1;
          end
        end
        rtc_i2c_pkg::S_RDATA: begin
          shreg   <= {shreg[6:0], 1'b0};
          bit_cnt <= 3'(bit_cnt + 3'h1);
          if (last_bit) begin
            byte_done <= 1'b1;
          end
        end
        rtc_i2c_pkg::S_MACK: begin
          mack_ok <= !sda_s;
          // Not-acknowledge ends the read; wait for stop or start
          if (sda_s) begin
            state <= rtc_i2c_pkg::S_IDLE;
          end
        end
        rtc_i2c_pkg::S_IDLE, rtc_i2c_pkg::S_ACK: begin
        end
        default: begin
          state <= rtc_i2c_pkg::S_IDLE;
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        rtc_i2c_pkg::S_ADDR, rtc_i2c_pkg::S_PTR,
        rtc_i2c_pkg::S_WDATA: begin
          if (byte_done) begin
            sda_drive <= 1'b1;
            byte_done <= 1'b0;
            state     <= rtc_i2c_pkg::S_ACK;
            if (state == rtc_i2c_pkg::S_ADDR) begin
              ret <= rw ? rtc_i2c_pkg::S_RDATA
                        : rtc_i2c_pkg::S_PTR;
            end else begin
              ret <= rtc_i2c_pkg::S_WDATA;
            end
          end
        end
        rtc_i2c_pkg::S_ACK: begin
          bit_cnt <= 3'h0;
          state   <= ret;
          if (ret == rtc_i2c_pkg::S_RDATA) begin
            shreg     <= mem[ptr];
            sda_drive <= !mem[ptr][7];
          end else begin
            sda_drive <= 1'b0;
          end
        end
        rtc_i2c_pkg::S_RDATA: begin
          if (byte_done) begin
            sda_drive <= 1'b0;
            byte_done <= 1'b0;
            mack_ok   <= 1'b0;
            state     <= rtc_i2c_pkg::S_MACK;
          end else begin
            sda_drive <= !shreg[7];
          end
        end
        rtc_i2c_pkg::S_MACK: begin
          if (mack_ok) begin
            shreg     <= mem[ptr];
            sda_drive <= !mem[ptr][7];
            bit_cnt   <= 3'h0;
            state     <= rtc_i2c_pkg::S_RDATA;
          end
        end
        rtc_i2c_pkg::S_IDLE: begin
        end
        default: begin
          state <= rtc_i2c_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Register pointer
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr <= rtc_i2c_pkg::PTR_RESET;
    end else if (ptr_load) begin
      if (rx_byte <= rtc_i2c_pkg::PTR_MAX) begin
        ptr <= rx_byte[5:0];
      end
    end else if (wr_fire) begin
      ptr <= inc_ptr(ptr);
    end else if (rd_step) begin
      ptr <= inc_ptr(ptr);
    end
  end

  // Register space; a bus write beats a core load in the same cycle
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < rtc_i2c_pkg::REG_COUNT; i++) begin
        mem[i] <= rtc_i2c_pkg::REG_RESET;
      end
    end else if (wr_fire) begin
      mem[ptr] <= rx_byte;
    end else if (LOAD_EN && LOAD_ADDR <= rtc_i2c_pkg::PTR_LAST) begin
      mem[LOAD_ADDR] <= LOAD_DATA;
    end
  end

  // Write notification
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WR_STROBE <= 1'b0;
      WR_ADDR   <= rtc_i2c_pkg::PTR_RESET;
      WR_DATA   <= rtc_i2c_pkg::REG_RESET;
    end else begin
      WR_STROBE <= wr_fire;
      if (wr_fire) begin
        WR_ADDR <= ptr;
        WR_DATA <= rx_byte;
      end
    end
  end

  assign PTR           = ptr;
  assign BUSY          = (state != rtc_i2c_pkg::S_IDLE);
  assign LINK.sda_s_o  = 1'b0;
  assign LINK.sda_s_oe = sda_drive;

endmodule : rtc_i2c_target

/* src/rtc_i2c_host.sv */
// Purpose: Host end of the RTC link, plus its write data buffer
// Assumes: Serial clock made from CLK, four quarters per bit
// Notes:   An empty buffer stalls the link with the serial clock held low
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;

  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW])
                       && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= (AW+1)'(wr_ptr + 1'b1);
      end
      if (out_valid && out_ready) begin
        rd_ptr <= (AW+1)'(rd_ptr + 1'b1);
      end
    end
  end
endmodule : byte_fifo

module rtc_i2c_host (
  // Link
  rtc_i2c_if.master          LINK,
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RST_N,
  // Command
  input  wire logic          CMD_VALID,
  output logic               CMD_READY,
  input  wire logic          CMD_READ,
  input  wire logic [7:0]    CMD_PTR,
  input  wire logic [7:0]    CMD_LEN,
  // Write data
  input  wire logic          WR_VALID,
  output logic               WR_READY,
  input  wire logic [7:0]    WR_DATA,
  // Read data and status
  output logic               RD_VALID,
  output logic      [7:0]    RD_DATA,
  output logic               DONE,
  output logic               NACK
);

  rtc_i2c_pkg::host_state_t st;
  rtc_i2c_pkg::host_step_t  step;
  logic [4:0]               qcnt;
  logic [1:0]               quarter;
  logic [3:0]               bitn;
  logic [7:0]               txb;
  logic [7:0]               rxb;
  logic                     ack_bit;
  logic                     cmd_read;
  logic [7:0]               cmd_ptr;
  logic [7:0]               remain;
  logic                     scl_low;
  logic                     sda_low;
  logic                     next_scl_low;
  logic                     next_sda_low;
  logic                     sda_q1;
  logic                     sda_in;
  logic                     tick;
  logic                     qend;
  logic                     byte_end;
  logic                     fetch;
  logic                     f_valid;
  logic                     f_pop;
  logic [7:0]               f_data;
  logic                     last;

  byte_fifo #(
    .WIDTH (rtc_i2c_pkg::BYTE_W),
    .DEPTH (rtc_i2c_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   (WR_DATA),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // Data line crosses in from the pin
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_q1 <= 1'b1;
      sda_in <= 1'b1;
    end else begin
      sda_q1 <= LINK.sda;
      sda_in <= sda_q1;
    end
  end

  assign tick     = (qcnt == rtc_i2c_pkg::QTR_LAST);
  assign qend     = tick && (quarter == 2'h3);
  assign byte_end = (st == rtc_i2c_pkg::ST_BYTE) && qend
                    && (bitn == rtc_i2c_pkg::ACK_BIT);
  assign last     = (remain == 8'h01);
  assign fetch    = (st == rtc_i2c_pkg::ST_HOLD)
                    || (byte_end && !ack_bit && remain != 8'h00
                        && ((step == rtc_i2c_pkg::STEP_PTR && !cmd_read)
                            || step == rtc_i2c_pkg::STEP_WDATA));
  assign f_pop    = fetch && f_valid;
  assign CMD_READY = (st == rtc_i2c_pkg::ST_IDLE);

  // Quarter-bit timer, held at zero while idle or stalled
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      qcnt    <= 5'h00;
      quarter <= 2'h0;
    end else if (st == rtc_i2c_pkg::ST_IDLE
                 || st == rtc_i2c_pkg::ST_HOLD) begin
      qcnt    <= 5'h00;
      quarter <= 2'h0;
    end else if (tick) begin
      qcnt    <= 5'h00;
      quarter <= 2'(quarter + 2'h1);
    end else begin
      qcnt <= 5'(qcnt + 5'h01);
    end
  end

  // Line levels; byte data changes in the second low quarter, start and stop data in the last high quarter
  always_comb begin
    next_scl_low = 1'b0;
    next_sda_low = sda_low;
    unique case (st)
      rtc_i2c_pkg::ST_IDLE: begin
        next_sda_low = 1'b0;
      end
      rtc_i2c_pkg::ST_START: begin
        next_scl_low = (quarter < 2'h2);
        if (quarter != 2'h0) begin
          next_sda_low = (quarter == 2'h3);
        end
      end
      rtc_i2c_pkg::ST_BYTE: begin
        next_scl_low = (quarter < 2'h2);
        if (quarter != 2'h0) begin
          if (bitn != rtc_i2c_pkg::ACK_BIT) begin
            next_sda_low = (step != rtc_i2c_pkg::STEP_RDATA) && !txb[7];
          end else begin
            next_sda_low = (step == rtc_i2c_pkg::STEP_RDATA)
                           && !last;
          end
        end
      end
      rtc_i2c_pkg::ST_HOLD: begin
        next_scl_low = 1'b1;
      end
      rtc_i2c_pkg::ST_STOP: begin
        next_scl_low = (quarter < 2'h2);
        if (quarter != 2'h0) begin
          next_sda_low = (quarter != 2'h3);
        end
      end
      default: begin
        next_sda_low = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  // Bit sampling at the end of the first high quarter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxb     <= 8'h00;
      ack_bit <= 1'b0;
    end else if (st == rtc_i2c_pkg::ST_BYTE && tick
                 && quarter == 2'h2) begin
      if (bitn == rtc_i2c_pkg::ACK_BIT) begin
        ack_bit <= sda_in;
      end else begin
        rxb <= {rxb[6:0], sda_in};
      end
    end
  end

  // Transfer sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st       <= rtc_i2c_pkg::ST_IDLE;
      step     <= rtc_i2c_pkg::STEP_ADDR_W;
      bitn     <= 4'h0;
      txb      <= 8'h00;
      cmd_read <= 1'b0;
      cmd_ptr  <= 8'h00;
      remain   <= 8'h00;
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
      DONE     <= 1'b0;
      NACK     <= 1'b0;
    end else begin
      RD_VALID <= 1'b0;
      DONE     <= 1'b0;
      if (f_pop) begin
        txb    <= f_data;
        remain <= 8'(remain - 8'h01);
        step   <= rtc_i2c_pkg::STEP_WDATA;
        st     <= rtc_i2c_pkg::ST_BYTE;
        bitn   <= 4'h0;
      end else if (fetch) begin
        st   <= rtc_i2c_pkg::ST_HOLD;
        step <= rtc_i2c_pkg::STEP_WDATA;
      end else if (st == rtc_i2c_pkg::ST_IDLE) begin
        if (CMD_VALID) begin
          st       <= rtc_i2c_pkg::ST_START;
          step     <= rtc_i2c_pkg::STEP_ADDR_W;
          txb      <= rtc_i2c_pkg::ADDR_BYTE_W;
          bitn     <= 4'h0;
          cmd_read <= CMD_READ;
          cmd_ptr  <= CMD_PTR;
          remain   <= CMD_LEN;
          NACK     <= 1'b0;
        end
      end else if (qend && st == rtc_i2c_pkg::ST_START) begin
        st <= rtc_i2c_pkg::ST_BYTE;
      end else if (qend && st == rtc_i2c_pkg::ST_STOP) begin
        st   <= rtc_i2c_pkg::ST_IDLE;
        DONE <= 1'b1;
      end else if (byte_end) begin
        bitn <= 4'h0;
        if (step != rtc_i2c_pkg::STEP_RDATA && ack_bit) begin
          NACK <= 1'b1;
          st   <= rtc_i2c_pkg::ST_STOP;
        end else begin
          unique case (step)
            rtc_i2c_pkg::STEP_ADDR_W: begin
              step <= rtc_i2c_pkg::STEP_PTR;
              txb  <= cmd_ptr;
            end
            rtc_i2c_pkg::STEP_PTR: begin
              if (remain == 8'h00) begin
                st <= rtc_i2c_pkg::ST_STOP;
              end else begin
                step <= rtc_i2c_pkg::STEP_ADDR_R;
                txb  <= rtc_i2c_pkg::ADDR_BYTE_R;
                st   <= rtc_i2c_pkg::ST_START;
              end
            end
            rtc_i2c_pkg::STEP_WDATA: begin
              st <= rtc_i2c_pkg::ST_STOP;
            end
            rtc_i2c_pkg::STEP_ADDR_R: begin
              step <= rtc_i2c_pkg::STEP_RDATA;
            end
            rtc_i2c_pkg::STEP_RDATA: begin
              RD_VALID <= 1'b1;
              RD_DATA  <= rxb;
              remain   <= 8'(remain - 8'h01);
              if (last) begin
                st <= rtc_i2c_pkg::ST_STOP;
              end
            end
            default: begin
              st <= rtc_i2c_pkg::ST_STOP;
            end
          endcase
        end
      end else if (qend && st == rtc_i2c_pkg::ST_BYTE) begin
        bitn <= 4'(bitn + 4'h1);
        txb  <= {txb[6:0], 1'b0};
      end
    end
  end

  assign LINK.scl_m_o  = 1'b0;
  assign LINK.scl_m_oe = scl_low;
  assign LINK.sda_m_o  = 1'b0;
  assign LINK.sda_m_oe = sda_low;

endmodule : rtc_i2c_host

/* dv/rtc_i2c_assertions.sv */
// Purpose: Wire-level checks on the host-target link
// Assumes: Sampled on the host clock, far faster than the serial clock
// Notes:   Open-drain, so enables are watched; the target driven level is only checked to be low
`timescale 1ns/100ps
module rtc_i2c_assertions (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ack_at_low_a: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("target took the line while clock high");
  drive_hold_a: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("target drive changed while clock high");
  low_only_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("target drove a high level");
  ack_long_a: assert property ($rose(sda_s_oe) |-> sda_s_oe[*8])
    else $error("target drive too short");
  start_clock_a: assert property (
    scl && $fell(sda) |-> ##[1:20] !scl)
    else $error("no clock after start");
  // A late release in the high phase would fake a stop
  stop_free_a: assert property (
    scl && $rose(sda) |-> !$past(sda_s_oe))
    else $error("target released the line during stop");
  high_len_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  low_len_a: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low phase too short");
endmodule : rtc_i2c_assertions

/* dv/rtc_i2c_register_access_tb.sv */
// Purpose: End-to-end register traffic between host and target
// Assumes: Load port of the target left idle
// Notes:   Expected bytes follow the pointer wrap at 2Fh
`timescale 1ns/100ps
module rtc_i2c_register_access_tb;
  logic       clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
  logic       on_battery = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0;
  logic [7:0] cmd_ptr = 8'h00, cmd_len = 8'h00, wr_data = 8'h00;
  logic       wr_valid = 1'b0;
  logic       cmd_ready, wr_ready, rd_valid, done, nack, wr_strobe, busy;
  logic [7:0] rd_data, tw_data;
  logic [5:0] ptr, wr_addr;
  logic [7:0] rq[$];
  logic [7:0] pat[5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
  int         errors = 0, check_count = 0, cycles = 0, strobes = 0;

  always #20 clk = ~clk;
  // Offset start keeps the two clocks out of step
  initial begin
    #2.5;
    forever #6 link_clk = ~link_clk;
  end

  rtc_i2c_if link ();
  rtc_i2c_host i_rtc_i2c_host (.LINK(link), .CLK(clk), .RST_N(rst_n),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
    .CMD_PTR(cmd_ptr), .CMD_LEN(cmd_len), .WR_VALID(wr_valid),
    .WR_READY(wr_ready), .WR_DATA(wr_data), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .DONE(done), .NACK(nack));
  rtc_i2c_target i_rtc_i2c_target (.LINK(link), .LINK_CLK(link_clk),
    .RST_N(rst_n), .ON_BATTERY(on_battery), .LOAD_EN(1'b0),
    .LOAD_ADDR(6'h00), .LOAD_DATA(8'h00), .WR_STROBE(wr_strobe),
    .WR_ADDR(wr_addr), .WR_DATA(tw_data), .PTR(ptr), .BUSY(busy));
  rtc_i2c_assertions i_rtc_i2c_assertions (.CLK(clk), .RST_N(rst_n),
    .scl(link.scl), .sda(link.sda), .sda_s_o(link.sda_s_o),
    .sda_s_oe(link.sda_s_oe));

  always @(posedge clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  always @(posedge link_clk) if (wr_strobe === 1'b1) strobes++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      finish_test();
    end
  end

  task automatic push(input logic [7:0] b);
    @(negedge clk);
    wr_valid = 1'b1;
    wr_data  = b;
    @(posedge clk);
    while (wr_ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask : push

  task automatic cmd(input logic rd, input logic [7:0] p, input logic [7:0] n);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_ptr   = p;
    cmd_len   = n;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 8000) errors++;
  endtask : wait_done

  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    // Full buffer first, so the fifth byte waits until the link takes the first
    for (int i = 0; i < 4; i++) push(pat[i]);
    check({7'h00, wr_ready}, 8'h00);
    cmd(1'b0, 8'h2D, 8'h05);
    push(pat[4]);
    wait_done();
    check({2'h0, ptr}, 8'h02);
    check({2'h0, wr_addr}, 8'h01);
    check(tw_data, 8'h55);
    check({7'h00, nack}, 8'h00);
    check(8'(strobes), 8'h05);
    check({6'h00, busy, cmd_ready}, 8'h01);
    $display("test 1 done");
    cmd(1'b1, 8'h2D, 8'h05);
    wait_done();
    check(8'(rq.size()), 8'h05);
    for (int i = 0; i < 5; i++) check(rq[i], pat[i]);
    check({2'h0, ptr}, 8'h02);
    $display("test 2 done");
    cmd(1'b0, 8'h30, 8'h01);
    push(8'hA5);
    wait_done();
    check({7'h00, nack}, 8'h00);
    check({2'h0, ptr}, 8'h02);
    check(8'(strobes), 8'h05);
    rq.delete();
    cmd(1'b1, 8'h2F, 8'h04);
    wait_done();
    check(8'(rq.size()), 8'h04);
    check(rq[0], 8'h33);
    check(rq[1], 8'h44);
    check(rq[3], 8'h00);
    check({2'h0, ptr}, 8'h03);
    $display("test 3 done");
    cmd(1'b0, 8'h10, 8'h00);
    wait_done();
    check({2'h0, ptr}, 8'h10);
    $display("test 4 done");
    on_battery = 1'b1;
    cmd(1'b0, 8'h05, 8'h00);
    wait_done();
    check({7'h00, nack}, 8'h01);
    check({2'h0, ptr}, 8'h10);
    on_battery = 1'b0;
    $display("test 5 done");
    finish_test();
  end
endmodule : rtc_i2c_register_access_tb
